// ### bsg_pkg.sv
// Package for the boot, status and general-purpose pin block.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package bsg_pkg;

	localparam int unsigned ADDR_W   = 6;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned GPIO_N   = 9;
	localparam int unsigned PWM_N    = 4;
	localparam int unsigned PWM_W    = 8;
	localparam int unsigned FEXT_N   = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL     = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_GPIO_DIR = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_GPIO_OD  = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_GPIO_OUT = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_GPIO_IN  = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_PWM_SEL  = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_PWM_DUTY = 6'h1C;
	localparam logic [ADDR_W-1:0] OFS_FLASH_EXT = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_SEQ_AUX  = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h28;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h2C;

	// Control register fields
	localparam int unsigned CTRL_INIT_DONE = 0;
	localparam int unsigned CTRL_SECONDARY = 1;
	localparam int unsigned CTRL_SPLIT     = 2;
	localparam int unsigned CTRL_FLT_HOLD  = 3;
	localparam int unsigned CTRL_FLT_TOG   = 4;
	localparam logic [4:0]  CTRL_RESET     = 5'h04;

	// Status register fields
	localparam int unsigned STAT_BOOTLOAD  = 0;
	localparam int unsigned STAT_ALIVE     = 1;
	localparam int unsigned STAT_SEQ_ONE   = 2;
	localparam int unsigned STAT_SEQ_TWO   = 3;

	// Interrupt status fields
	localparam int unsigned IRQ_SEQ_ONE    = 0;
	localparam int unsigned IRQ_SEQ_TWO    = 1;
	localparam int unsigned IRQ_FAULT      = 2;
	localparam int unsigned IRQ_N          = 3;

	// Alive indicator timing
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned ALIVE_PERIOD_MS = 1000;
	localparam int unsigned ALIVE_HALF_CYC  =
		ALIVE_PERIOD_MS * 1000000 / CLK_PERIOD_NS / 2;

	typedef enum logic [1:0] {
		BSG_BOOT_WAIT,
		BSG_BOOT_LOADER,
		BSG_BOOT_NORMAL
	} bsg_boot_e;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} bsg_avm_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] readdata;
		logic              waitrequest;
	} bsg_avm_rsp_s;

endpackage : bsg_pkg

// ### bsg_top.sv
// Boot select, status indicators, sequencing loopback and GPIO pins.
// Assumes pin inputs synchronous to clk_i and a single Avalon-MM master.
`timescale 1ns/100ps
module bsg_top
	import bsg_pkg::*;
#(
	parameter int unsigned ALIVE_HALF = bsg_pkg::ALIVE_HALF_CYC,
	parameter int unsigned GPIO_CNT   = bsg_pkg::GPIO_N
) (
	input  wire logic                          clk_i,
	input  wire logic                          reset_n_i,
	input  wire bsg_pkg::bsg_avm_req_s         avm_req_i,
	output bsg_pkg::bsg_avm_rsp_s              avm_rsp_o,
	output logic                               irq_o,
	input  wire logic                          boot_select_n_i,
	output logic                               bootloader_mode_o,
	output logic                               normal_mode_o,
	output logic                               usb_buffer_enable_n_o,
	output logic                               usb_buffer_enable_oe_o,
	output logic                               fault_status_o,
	output logic                               alive_indicator_o,
	input  wire logic                          seq_irq_in_one_i,
	input  wire logic                          seq_irq_in_two_i,
	output logic                               seq_aux_out_six_o,
	output logic                               seq_aux_out_seven_o,
	input  wire logic                          split_config_in_i,
	output logic                               split_config_out_o,
	output logic                               split_config_oe_o,
	input  wire logic [bsg_pkg::GPIO_N-1:0]    gpio_i,
	output logic      [bsg_pkg::GPIO_N-1:0]    gpio_o,
	output logic      [bsg_pkg::GPIO_N-1:0]    gpio_oe_o,
	output logic      [bsg_pkg::FEXT_N-1:0]    flash_addr_ext_o
);
	import bsg_pkg::*;

	localparam int unsigned AW = $clog2(ALIVE_HALF + 1);

	if (GPIO_CNT != GPIO_N || ALIVE_HALF < 1) begin : g_chk
		$error("bsg_top: unsupported parameter values");
	end

	// Pin driver: open-drain drives only low
	function automatic logic [1:0] pin_drive(input logic val,
		input logic dir, input logic od, input logic off);
		logic [1:0] r;
		r = 2'h0;
		if (!off && dir) begin
			r = od ? {1'b0, ~val} : {val, 1'b1};
		end
		return r;
	endfunction : pin_drive

	logic [4:0]           ctrl_r;
	logic [GPIO_N-1:0]    dir_r, od_r, out_r;
	logic [PWM_N-1:0]     pwm_sel_r;
	logic [PWM_W-1:0]     duty_r [PWM_N];
	logic [FEXT_N-1:0]    fext_r;
	logic [1:0]           aux_r;
	logic [IRQ_N-1:0]     irq_stat_r, irq_mask_r, irq_stat_nxt;
	logic [DATA_W-1:0]    rdata_r;
	logic                 ack_r;
	bsg_boot_e            boot_r;
	logic [AW-1:0]        alive_cnt_r;
	logic                 alive_r;
	logic [PWM_W-1:0]     pwm_cnt_r;
	logic                 seq_one_d_r, seq_two_d_r, fault_d_r;

	// Bus decode
	wire req       = avm_req_i.read | avm_req_i.write;
	wire take      = req & ack_r;
	wire wr_take   = take & avm_req_i.write;
	wire rd_first  = avm_req_i.read & ~ack_r;
	wire [ADDR_W-1:0] adr = avm_req_i.address;
	wire [DATA_W-1:0] wd  = avm_req_i.writedata;
	wire wr_ctrl  = wr_take && adr == OFS_CTRL;
	wire wr_dir   = wr_take && adr == OFS_GPIO_DIR;
	wire wr_od    = wr_take && adr == OFS_GPIO_OD;
	wire wr_out   = wr_take && adr == OFS_GPIO_OUT;
	wire wr_psel  = wr_take && adr == OFS_PWM_SEL;
	wire wr_duty  = wr_take && adr == OFS_PWM_DUTY;
	wire wr_fext  = wr_take && adr == OFS_FLASH_EXT;
	wire wr_aux   = wr_take && adr == OFS_SEQ_AUX;
	wire wr_mask  = wr_take && adr == OFS_IRQ_MASK;
	wire rd_istat = take && avm_req_i.read && adr == OFS_IRQ_STAT;
	// Only bits already reported are cleared; a wait-cycle event survives
	wire [IRQ_N-1:0] istat_seen = rdata_r[IRQ_N-1:0];

	wire secondary = ctrl_r[CTRL_SECONDARY];
	wire init_done = ctrl_r[CTRL_INIT_DONE];
	wire operational = init_done && boot_r == BSG_BOOT_NORMAL;
	wire fault_act = ctrl_r[CTRL_FLT_HOLD]
		| (ctrl_r[CTRL_FLT_TOG] & alive_r);

	wire [DATA_W-1:0] status_w = {28'h0000000, seq_irq_in_two_i,
		seq_irq_in_one_i, alive_r, boot_r == BSG_BOOT_LOADER};
	logic [DATA_W-1:0] duty_w;
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		duty_w = '0;
		for (int k = 0; k < PWM_N; k++) begin
			duty_w[k*PWM_W +: PWM_W] = duty_r[k];
		end
	end

	always_comb begin
		if (adr == OFS_CTRL)           rd_mux = DATA_W'(ctrl_r);
		else if (adr == OFS_STATUS)    rd_mux = status_w;
		else if (adr == OFS_GPIO_DIR)  rd_mux = DATA_W'(dir_r);
		else if (adr == OFS_GPIO_OD)   rd_mux = DATA_W'(od_r);
		else if (adr == OFS_GPIO_OUT)  rd_mux = DATA_W'(out_r);
		else if (adr == OFS_GPIO_IN)   rd_mux = DATA_W'(gpio_i);
		else if (adr == OFS_PWM_SEL)   rd_mux = DATA_W'(pwm_sel_r);
		else if (adr == OFS_PWM_DUTY)  rd_mux = duty_w;
		else if (adr == OFS_FLASH_EXT) rd_mux = DATA_W'(fext_r);
		else if (adr == OFS_SEQ_AUX)   rd_mux = DATA_W'(aux_r);
		else if (adr == OFS_IRQ_STAT)  rd_mux = DATA_W'(irq_stat_r);
		else if (adr == OFS_IRQ_MASK)  rd_mux = DATA_W'(irq_mask_r);
		else                           rd_mux = '0;
	end

	// One wait cycle, answer on the second edge
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_r   <= 1'b0;
			rdata_r <= '0;
		end else begin
			ack_r <= req & ~ack_r;
			if (rd_first) rdata_r <= rd_mux;
		end
	end

	assign avm_rsp_o.waitrequest = req & ~ack_r;
	assign avm_rsp_o.readdata    = rdata_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r     <= CTRL_RESET;
			dir_r      <= '0;
			od_r       <= '0;
			out_r      <= '0;
			pwm_sel_r  <= '0;
			fext_r     <= '0;
			aux_r      <= '0;
			irq_mask_r <= '0;
		end else begin
			if (wr_ctrl) ctrl_r <= wd[4:0] | {4'h0, init_done};
			if (wr_dir)  dir_r  <= wd[GPIO_N-1:0];
			if (wr_od)   od_r   <= wd[GPIO_N-1:0];
			if (wr_out)  out_r  <= wd[GPIO_N-1:0];
			if (wr_psel) pwm_sel_r <= wd[PWM_N-1:0];
			if (wr_fext) fext_r <= wd[FEXT_N-1:0];
			if (wr_aux)  aux_r  <= wd[1:0];
			if (wr_mask) irq_mask_r <= wd[IRQ_N-1:0];
		end
	end

	for (genvar k = 0; k < PWM_N; k++) begin : g_duty
		always_ff @(posedge clk_i or negedge reset_n_i) begin
			if (!reset_n_i) duty_r[k] <= '0;
			else if (wr_duty) duty_r[k] <= wd[k*PWM_W +: PWM_W];
		end
	end

	// Boot strap caught on the first edge after reset release
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_r <= BSG_BOOT_WAIT;
		end else begin
			case (boot_r)
				BSG_BOOT_WAIT:
					boot_r <= boot_select_n_i ? BSG_BOOT_NORMAL
						: BSG_BOOT_LOADER;
				default: boot_r <= boot_r;
			endcase
		end
	end

	assign bootloader_mode_o = boot_r == BSG_BOOT_LOADER;
	assign normal_mode_o     = boot_r == BSG_BOOT_NORMAL;

	// Alive toggling, half period per count
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			alive_cnt_r <= '0;
			alive_r     <= 1'b0;
		end else if (!operational) begin
			alive_cnt_r <= '0;
		end else if (alive_cnt_r == AW'(ALIVE_HALF - 1)) begin
			alive_cnt_r <= '0;
			alive_r     <= ~alive_r;
		end else begin
			alive_cnt_r <= alive_cnt_r + 1'b1;
		end
	end

	assign alive_indicator_o = alive_r;
	assign fault_status_o    = fault_act;

	// Sticky events, set beats clear-on-read
	assign irq_stat_nxt = {fault_act & ~fault_d_r,
		seq_irq_in_two_i & ~seq_two_d_r,
		seq_irq_in_one_i & ~seq_one_d_r};

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seq_one_d_r <= 1'b0;
			seq_two_d_r <= 1'b0;
			fault_d_r   <= 1'b0;
			irq_stat_r  <= '0;
		end else begin
			seq_one_d_r <= seq_irq_in_one_i;
			seq_two_d_r <= seq_irq_in_two_i;
			fault_d_r   <= fault_act;
			irq_stat_r  <= (rd_istat ? irq_stat_r & ~istat_seen
				: irq_stat_r) | irq_stat_nxt;
		end
	end

	assign irq_o = |(irq_stat_r & irq_mask_r);

	// Sequencing interrupt outputs, looped back externally
	assign seq_aux_out_six_o   = aux_r[0];
	assign seq_aux_out_seven_o = aux_r[1];

	assign usb_buffer_enable_n_o  = ~(init_done & ~secondary);
	assign usb_buffer_enable_oe_o = ~secondary;
	assign split_config_out_o     = ctrl_r[CTRL_SPLIT];
	assign split_config_oe_o      = ~secondary;
	assign flash_addr_ext_o       = fext_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) pwm_cnt_r <= '0;
		else pwm_cnt_r <= pwm_cnt_r + 1'b1;
	end

	for (genvar k = 0; k < GPIO_N; k++) begin : g_pin
		logic val;
		logic [1:0] drv;
		if (k < PWM_N) begin : g_pwm
			assign val = pwm_sel_r[k] ? (pwm_cnt_r < duty_r[k])
				: out_r[k];
		end else begin : g_plain
			assign val = out_r[k];
		end
		assign drv = pin_drive(val, dir_r[k], od_r[k], secondary);
		assign gpio_o[k]    = drv[1];
		assign gpio_oe_o[k] = drv[0];
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	boot_low_a: assert property (boot_r == BSG_BOOT_WAIT
		&& reset_n_i && !boot_select_n_i |=> bootloader_mode_o)
		else $error("low boot select did not enter bootloader");
	boot_high_a: assert property (boot_r == BSG_BOOT_WAIT
		&& reset_n_i && boot_select_n_i |=> normal_mode_o)
		else $error("high boot select did not enter normal mode");
	usb_enable_a: assert property (!usb_buffer_enable_n_o |->
		init_done && !secondary)
		else $error("usb buffer enabled before init");
	fault_hold_a: assert property (ctrl_r[CTRL_FLT_HOLD] |->
		fault_status_o)
		else $error("fault hold not shown");
	alive_period_a: assert property ($changed(alive_r) |->
		operational && $past(alive_cnt_r) == AW'(ALIVE_HALF - 1))
		else $error("alive toggled off schedule");
	seq_irq_a: assert property ($rose(seq_irq_in_one_i) |=>
		irq_stat_r[IRQ_SEQ_ONE])
		else $error("sequencing event lost");
	gpio_reset_a: assert property ($rose(reset_n_i) |->
		gpio_oe_o == '0) else $error("gpio driven after reset");
	open_drain_a: assert property (od_r[4] && gpio_oe_o[4] |->
		!gpio_o[4]) else $error("open-drain pin drove high");
	secondary_off_a: assert property (secondary |->
		gpio_oe_o == '0 && !split_config_oe_o)
		else $error("secondary drove marked pins");
	pwm_mux_a: assert property (pwm_sel_r[0] && dir_r[0] && !od_r[0]
		&& !secondary |-> gpio_o[0] == (pwm_cnt_r < duty_r[0]))
		else $error("pwm not routed to pin");
	bus_wait_a: assert property (req && !ack_r |=> ack_r || !req)
		else $error("bus wait longer than one cycle");

	// Strap, indicator, pin, interrupt and bus checks
	boot_hold_a: assert property (boot_r != BSG_BOOT_WAIT |=>
		$stable(boot_r))
		else $error("boot mode changed after start-up");
	alive_still_a: assert property (!operational |=>
		$stable(alive_r))
		else $error("alive toggled while not operational");
	fault_edge_a: assert property ($rose(fault_status_o) |=>
		irq_stat_r[IRQ_FAULT])
		else $error("fault event lost");
	seq_two_a: assert property ($rose(seq_irq_in_two_i) |=>
		irq_stat_r[IRQ_SEQ_TWO])
		else $error("second sequencing event lost");
	split_reset_a: assert property ($rose(reset_n_i) |->
		split_config_out_o && split_config_oe_o)
		else $error("split configuration not high after reset");
	usb_reset_a: assert property ($rose(reset_n_i) |->
		usb_buffer_enable_n_o)
		else $error("usb buffer enabled at reset");
	gpio_input_a: assert property (dir_r == '0 |->
		gpio_oe_o == '0)
		else $error("input pin driven");
	plain_pin_a: assert property (dir_r[4] && !od_r[4] && !secondary
		|-> gpio_oe_o[4] && gpio_o[4] == out_r[4])
		else $error("plain pin not driven from its register");
	fext_write_a: assert property (wr_fext |=>
		flash_addr_ext_o == $past(wd[FEXT_N-1:0]))
		else $error("flash address extension not updated");
	usb_oe_a: assert property (!secondary |->
		usb_buffer_enable_oe_o && split_config_oe_o)
		else $error("primary released its marked pins");
	irq_clear_a: assert property (rd_istat && irq_stat_nxt == '0 |=>
		(irq_stat_r & $past(istat_seen)) == '0)
		else $error("reported interrupt not cleared");
	read_data_a: assert property (rd_first |=>
		avm_rsp_o.readdata == $past(rd_mux))
		else $error("read data not held for the accept edge");
	wait_first_a: assert property ($rose(req) |->
		avm_rsp_o.waitrequest)
		else $error("no wait cycle on a new request");

	boot_loader_c: cover property (bootloader_mode_o);
	alive_toggle_c: cover property ($rose(alive_r));
	irq_raise_c: cover property ($rose(irq_o));
	od_pin_c: cover property (od_r[4] && !gpio_oe_o[4]);
	secondary_c: cover property (secondary && dir_r[0]);

endmodule : bsg_top

// ### bsg_board.sv
// Board model around the pin block: strap, pull-ups and loopbacks.
// Assumes the bench sets the boot strap level and that pins are wired.
`timescale 1ns/100ps
module bsg_board
	import bsg_pkg::*;
(
	input  wire logic                       boot_low_i,
	input  wire logic [bsg_pkg::GPIO_N-1:0] dev_gpio_i,
	input  wire logic [bsg_pkg::GPIO_N-1:0] dev_gpio_oe_i,
	input  wire logic                       aux_six_i,
	input  wire logic                       aux_seven_i,
	input  wire logic                       split_out_i,
	input  wire logic                       split_oe_i,
	output logic      [bsg_pkg::GPIO_N-1:0] gpio_pin_o,
	output logic                            seq_one_o,
	output logic                            seq_two_o,
	output logic                            boot_n_o,
	output logic                            split_pin_o
);
	logic split_last = 1'b0;

	// Strap resistor pulls high unless the jumper is fitted
	assign boot_n_o = ~boot_low_i;
	// Undriven or released lines float up through the pull-ups
	assign gpio_pin_o = (dev_gpio_oe_i & dev_gpio_i) | ~dev_gpio_oe_i;
	assign seq_two_o = aux_six_i;
	assign seq_one_o = aux_seven_i;
	// An undriven configuration line shows the inverse of its last level
	always @(split_out_i, split_oe_i) begin
		if (split_oe_i)
			split_last = split_out_i;
	end
	assign split_pin_o = split_oe_i ? split_out_i : ~split_last;
endmodule : bsg_board

// ### bsg_top_bench.sv
// Self-checking bench for the boot, status and general-purpose pin block.
// Assumes the board model and a shortened alive half period of 4 cycles.
`timescale 1ns/100ps
module bsg_top_bench;
	import bsg_pkg::*;
	logic              clk_i = 0, reset_n_i = 0, boot_low = 0;
	bsg_avm_req_s      avm_req_i = '0;
	bsg_avm_rsp_s      avm_rsp_o;
	logic              irq_o, boot_select_n_i, bootloader_mode_o;
	logic              normal_mode_o, usb_buffer_enable_n_o;
	logic              usb_buffer_enable_oe_o, fault_status_o;
	logic              alive_indicator_o, seq_irq_in_one_i;
	logic              seq_irq_in_two_i, seq_aux_out_six_o;
	logic              seq_aux_out_seven_o, split_config_in_i;
	logic              split_config_out_o, split_config_oe_o;
	logic [GPIO_N-1:0] gpio_i, gpio_o, gpio_oe_o;
	logic [FEXT_N-1:0] flash_addr_ext_o;
	logic [31:0]       rd;
	int                err_total = 0, num_checks = 0, cyc = 0, h, t;

	bsg_top #(.ALIVE_HALF(4)) dut (.clk_i, .reset_n_i, .avm_req_i,
		.avm_rsp_o, .irq_o, .boot_select_n_i, .bootloader_mode_o,
		.normal_mode_o, .usb_buffer_enable_n_o, .usb_buffer_enable_oe_o,
		.fault_status_o, .alive_indicator_o, .seq_irq_in_one_i,
		.seq_irq_in_two_i, .seq_aux_out_six_o, .seq_aux_out_seven_o,
		.split_config_in_i, .split_config_out_o, .split_config_oe_o,
		.gpio_i, .gpio_o, .gpio_oe_o, .flash_addr_ext_o);
	bsg_board board (.boot_low_i(boot_low), .dev_gpio_i(gpio_o),
		.dev_gpio_oe_i(gpio_oe_o), .aux_six_i(seq_aux_out_six_o),
		.aux_seven_i(seq_aux_out_seven_o), .split_out_i(split_config_out_o),
		.split_oe_i(split_config_oe_o), .gpio_pin_o(gpio_i),
		.seq_one_o(seq_irq_in_one_i), .seq_two_o(seq_irq_in_two_i),
		.boot_n_o(boot_select_n_i), .split_pin_o(split_config_in_i));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			stop_test();
		end
	end

	task stop_test;
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until the edge that sees waitrequest low
	task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk_i);
		avm_req_i <= '{read: ~w, write: w, address: a, writedata: d};
		do begin
			@(posedge clk_i);
		end while (avm_rsp_o.waitrequest !== 1'b0);
		rd = avm_rsp_o.readdata;
		avm_req_i <= '0;
		@(negedge clk_i);
	endtask : bus

	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk

	function logic sig(input int s);
		return s == 0 ? alive_indicator_o : s == 1 ? fault_status_o : gpio_o[0];
	endfunction : sig

	// Counts high samples and level changes over n cycles
	task cnt(input int s, input int n);
		logic p;
		logic v;
		h = 0;
		t = 0;
		p = sig(s);
		for (int k = 0; k < n; k++) begin
			@(negedge clk_i);
			v = sig(s);
			h += int'(v);
			t += int'(v != p);
			p = v;
		end
	endtask : cnt

	task do_reset(input logic low);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		boot_low <= low;
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(negedge clk_i);
	endtask : do_reset

	task t_defaults;
		chk(gpio_oe_o, 9'h000);
		chk(usb_buffer_enable_n_o, 1'b1);
		chk({split_config_out_o, split_config_oe_o}, 2'h3);
		chk({normal_mode_o, bootloader_mode_o}, 2'h2);
		rchk(OFS_CTRL, 32'h04);
		rchk(6'h30, 32'h0);
	endtask : t_defaults

	task t_irq;
		wr(OFS_IRQ_MASK, 32'h0);
		wr(OFS_SEQ_AUX, 32'h1);
		rchk(OFS_STATUS, 32'h8);
		chk(irq_o, 1'b0);
		rchk(OFS_IRQ_STAT, 32'h2);
		rchk(OFS_IRQ_STAT, 32'h0);
		wr(OFS_IRQ_MASK, 32'h7);
		wr(OFS_SEQ_AUX, 32'h3);
		rchk(OFS_STATUS, 32'hC);
		chk(irq_o, 1'b1);
		rchk(OFS_IRQ_STAT, 32'h1);
		chk(irq_o, 1'b0);
		wr(OFS_CTRL, 32'h0C);
		chk(fault_status_o, 1'b1);
		rchk(OFS_IRQ_STAT, 32'h4);
	endtask : t_irq

	task t_gpio;
		wr(OFS_GPIO_DIR, 32'h1FF);
		wr(OFS_GPIO_OUT, 32'h155);
		chk(gpio_oe_o, 9'h1FF);
		rchk(OFS_GPIO_IN, 32'h155);
		wr(OFS_GPIO_OD, 32'h1FF);
		chk({gpio_oe_o, gpio_o}, {9'h0AA, 9'h000});
		rchk(OFS_GPIO_IN, 32'h155);
		wr(OFS_GPIO_OD, 32'h0);
		wr(OFS_PWM_SEL, 32'hF);
		chk(gpio_o, 9'h150);
		wr(OFS_PWM_DUTY, 32'h80);
		cnt(2, 256);
		chk(h, 128);
		wr(OFS_FLASH_EXT, 32'h5);
		chk(flash_addr_ext_o, 3'h5);
		rchk(OFS_FLASH_EXT, 32'h5);
	endtask : t_gpio

	task t_oper;
		wr(OFS_CTRL, 32'h05);
		chk({usb_buffer_enable_n_o, usb_buffer_enable_oe_o}, 2'h1);
		cnt(0, 16);
		chk(t, 4);
		wr(OFS_CTRL, 32'h14);
		chk(usb_buffer_enable_n_o, 1'b0);
		cnt(1, 16);
		chk(t, 4);
	endtask : t_oper

	task t_second;
		wr(OFS_CTRL, 32'h07);
		chk(gpio_oe_o, 9'h000);
		chk({usb_buffer_enable_oe_o, split_config_oe_o}, 2'h0);
		wr(OFS_FLASH_EXT, 32'h2);
		chk(flash_addr_ext_o, 3'h2);
	endtask : t_second

	task t_boot;
		chk({normal_mode_o, bootloader_mode_o}, 2'h1);
		rchk(OFS_STATUS, 32'h1);
		wr(OFS_CTRL, 32'h05);
		cnt(0, 16);
		chk(t, 0);
	endtask : t_boot

	initial begin
		do_reset(1'b0);
		t_defaults();
		t_irq();
		t_gpio();
		t_oper();
		t_second();
		do_reset(1'b1);
		t_boot();
		stop_test();
	end
endmodule : bsg_top_bench
